// *** spos_pkg.sv ***
package spos_pkg;

   // register port geometry
   localparam int          ADDR_W         = 16;
   localparam int          DATA_W         = 8;

   // register offsets
   localparam logic [15:0] UPDATE_ADDR    = 16'h000F;
   localparam logic [15:0] SYS_STAT_ADDR  = 16'h0D01;
   localparam logic [15:0] REF_STAT_BASE  = 16'h0D02;
   localparam logic [15:0] EVENT_ADDR     = 16'h0D0C;
   localparam logic [15:0] LOOP0_BASE     = 16'h0D20;
   localparam logic [15:0] LOOP1_OFFSET   = 16'h0020;
   localparam logic [15:0] LOOP2_OFFSET   = 16'h0040;
   localparam logic [15:0] LOOP3_OFFSET   = 16'h0060;
   localparam logic [15:0] PIN_CODE_ADDR  = 16'h0200;

   // bank geometry: 0x0D20..0x0D2A
   localparam int          BANK_BYTES     = 11;
   localparam int          REF_COUNT      = 4;

   // values
   localparam logic [7:0]  UPDATE_GO      = 8'h01;
   localparam logic [7:0]  STATUS_RST     = 8'h00;
   localparam logic [7:0]  PIN_CODE_RST   = 8'h80;
   localparam logic [7:0]  UNMAPPED_READ  = 8'h00;

   // cycle counts
   localparam int          CLK_DIV_RATIO  = 32;
   localparam int          WD_STROBE_CYC  = 32;

   // field positions
   localparam int          BIT_DIR        = 7;
   localparam int          SYS_LOCK_BIT   = 0;
   localparam int          SYS_STABLE_BIT = 1;
   localparam int          SYS_CAL_BIT    = 2;
   localparam int          EVT_HIST_BIT   = 4;
   localparam int          REF_FAULT_BIT  = 2;
   localparam int          REF_VALID_BIT  = 3;
   localparam int          REF_USE_LSB    = 4;
   localparam int          S0_PHASE_BIT   = 1;
   localparam int          S0_FREQ_BIT    = 2;
   localparam int          S0_ALOCK_BIT   = 3;
   localparam int          S0_ACAL_BIT    = 4;
   localparam int          S1_FREE_BIT    = 0;
   localparam int          S1_HOLD_BIT    = 1;
   localparam int          S1_SWITCH_BIT  = 2;
   localparam int          S2_HIST_BIT    = 0;
   localparam int          S2_FCLAMP_BIT  = 1;
   localparam int          S2_SLEW_BIT    = 2;
   localparam int          S2_DEMAP_BIT   = 3;

   // function code groups, upper nibble
   localparam logic [3:0]  GRP_MISC       = 4'h8;
   localparam logic [3:0]  GRP_IRQ        = 4'h9;
   localparam logic [3:0]  GRP_REF        = 4'hA;
   localparam logic [3:0]  GRP_REF_USE    = 4'hB;

endpackage

// *** spos_strobe_gen.sv ***
`timescale 1ns/1ps
module spos_strobe_gen #(
   parameter int DIV_RATIO  = spos_pkg::CLK_DIV_RATIO,
   parameter int STROBE_LEN = spos_pkg::WD_STROBE_CYC
) (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic wd_expire,
   output logic      div_clk,
   output logic      wd_strobe
);
   localparam int HALF = DIV_RATIO / 2;
   localparam int CW   = $clog2(DIV_RATIO + STROBE_LEN + 1);

   logic [CW-1:0] div_cnt_q;
   logic [CW-1:0] wd_cnt_q;

   // square wave, one toggle each half period
   always_ff @(posedge mclk) begin
      if (rst) begin
         div_cnt_q <= '0;
         div_clk   <= 1'b0;
      end else if (div_cnt_q == CW'(HALF - 1)) begin
         div_cnt_q <= '0;
         div_clk   <= ~div_clk;
      end else begin
         div_cnt_q <= div_cnt_q + 1'b1;
      end
   end

   // a new expiry during a strobe restarts the full length
   always_ff @(posedge mclk) begin
      if (rst) begin
         wd_cnt_q  <= '0;
         wd_strobe <= 1'b0;
      end else if (wd_expire) begin
         wd_cnt_q  <= CW'(STROBE_LEN - 1);
         wd_strobe <= 1'b1;
      end else if (wd_cnt_q != '0) begin
         wd_cnt_q  <= wd_cnt_q - 1'b1;
      end else begin
         wd_strobe <= 1'b0;
      end
   end
endmodule // spos_strobe_gen

// *** spos_status_bank.sv ***
`timescale 1ns/1ps
module spos_status_bank #(
   parameter int BYTES = spos_pkg::BANK_BYTES
) (
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             capture,
   input  wire logic [BYTES*8-1:0] live,
   input  wire logic [3:0]       rd_idx,
   output logic [7:0]            rd_byte
);
   logic [7:0] snap_q [BYTES];

   // only the snapshot strobe loads the bank; no host write path exists
   always_ff @(posedge mclk) begin
      for (int i = 0; i < BYTES; i++) begin
         if (rst) begin
            snap_q[i] <= spos_pkg::STATUS_RST;
         end else if (capture) begin
            snap_q[i] <= live[i*8 +: 8];
         end
      end
   end

   always_comb begin
      rd_byte = spos_pkg::UNMAPPED_READ;
      if (int'(rd_idx) < BYTES) begin
         rd_byte = snap_q[rd_idx];
      end
   end
endmodule // spos_status_bank

// *** spos_pin_select.sv ***
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module spos_pin_select #(
   parameter int LOOPS      = 4,
   parameter int DIV_RATIO  = spos_pkg::CLK_DIV_RATIO,
   parameter int STROBE_LEN = spos_pkg::WD_STROBE_CYC
) (
   input  wire logic                           mclk,
   input  wire logic                           rst,
   input  wire logic [spos_pkg::ADDR_W-1:0]    reg_addr,
   input  wire logic [spos_pkg::DATA_W-1:0]    reg_wdata,
   input  wire logic                           reg_wr,
   input  wire logic                           reg_rd,
   output logic      [spos_pkg::DATA_W-1:0]    reg_rdata,
   input  wire logic [LOOPS*spos_pkg::BANK_BYTES*8-1:0] loop_status,
   input  wire logic                           refmult_lock,
   input  wire logic                           refmult_stable,
   input  wire logic                           refmult_cal_busy,
   input  wire logic [spos_pkg::REF_COUNT*8-1:0] ref_status,
   input  wire logic [7:0]                     event_status,
   input  wire logic                           irq_common,
   input  wire logic [LOOPS-1:0]               irq_loop,
   input  wire logic                           wd_expire,
   output logic                                mfp_out,
   output logic                                mfp_oe_n,
   output logic                                update_busy
);
   localparam int BB = spos_pkg::BANK_BYTES;
   localparam int LW = BB * 8;

   logic [7:0]       pin_code_q;
   logic [7:0]       rdata_d;
   logic             capture;
   logic             div_clk;
   logic             wd_strobe;
   logic             pin_d;
   logic [7:0]       sys_live;
   logic [7:0]       sys_snap_q;
   logic [31:0]      ref_snap_q;
   logic [7:0]       evt_snap_q;
   logic [LOOPS-1:0] comb_lock;
   logic [7:0]       bank_byte [LOOPS];
   logic [3:0]       bank_idx;
   logic [1:0]       sel_loop;
   logic [3:0]       sub;
   // selected bytes: a bit select on a function result is not legal, so name them
   logic [7:0]       sel_b0;
   logic [7:0]       sel_b1;
   logic [7:0]       sel_b2;
   logic [7:0]       sel_ref;

   // byte idx of loop l's live status
   function automatic logic [7:0] loop_byte(input logic [LOOPS*LW-1:0] v,
                                            input int l, input int idx);
      loop_byte = v[l*LW + idx*8 +: 8];
   endfunction

   // byte of reference r in a packed reference vector
   function automatic logic [7:0] ref_byte(input logic [31:0] v, input int r);
      ref_byte = v[r*8 +: 8];
   endfunction

   // true when address a falls inside the bank that starts at base b
   function automatic logic in_bank(input logic [15:0] a, input logic [15:0] b);
      in_bank = (a >= b) && (a < b + 16'(BB));
   endfunction

   // ---------------------------------------------------------------
   // snapshot strobe and control register
   // ---------------------------------------------------------------

   // self-clearing: only the exact go value triggers a snapshot
   assign capture = reg_wr && (reg_addr == spos_pkg::UPDATE_ADDR)
                    && (reg_wdata == spos_pkg::UPDATE_GO);

   always_ff @(posedge mclk) begin
      if (rst) begin
         pin_code_q <= spos_pkg::PIN_CODE_RST;
      end else if (reg_wr && reg_addr == spos_pkg::PIN_CODE_ADDR) begin
         pin_code_q <= reg_wdata;
      end
   end

   // high for the one cycle after the edge that loads the snapshot
   always_ff @(posedge mclk) begin
      if (rst) begin
         update_busy <= 1'b0;
      end else begin
         update_busy <= capture;
      end
   end

   // ---------------------------------------------------------------
   // live system status and combined locks
   // ---------------------------------------------------------------

   always_comb begin
      for (int l = 0; l < LOOPS; l++) begin
         comb_lock[l] = loop_status[l*LW + spos_pkg::S0_PHASE_BIT]
                        & loop_status[l*LW + spos_pkg::S0_ALOCK_BIT]
                        & refmult_lock;
      end
   end

   always_comb begin
      sys_live = 8'h00;
      sys_live[spos_pkg::SYS_LOCK_BIT]   = refmult_lock;
      sys_live[spos_pkg::SYS_STABLE_BIT] = refmult_stable;
      sys_live[spos_pkg::SYS_CAL_BIT]    = refmult_cal_busy;
      sys_live[7:4]                      = comb_lock[3:0];
   end

   // system, reference and event bytes share the loop banks' snapshot
   always_ff @(posedge mclk) begin
      if (rst) begin
         sys_snap_q <= spos_pkg::STATUS_RST;
         ref_snap_q <= {spos_pkg::REF_COUNT{spos_pkg::STATUS_RST}};
         evt_snap_q <= spos_pkg::STATUS_RST;
      end else if (capture) begin
         sys_snap_q <= sys_live;
         ref_snap_q <= ref_status;
         evt_snap_q <= event_status;
      end
   end

   // ---------------------------------------------------------------
   // per-loop status banks
   // ---------------------------------------------------------------

   // all banks share one reset value and one layout
   for (genvar g = 0; g < LOOPS; g++) begin : g_bank
      spos_status_bank #(
         .BYTES   (BB)
      ) u_bank (
         .mclk    (mclk),
         .rst     (rst),
         .capture (capture),
         .live    (loop_status[g*LW +: LW]),
         .rd_idx  (bank_idx),
         .rd_byte (bank_byte[g])
      );
   end

   assign bank_idx = reg_addr[3:0];

   // ---------------------------------------------------------------
   // read decode
   // ---------------------------------------------------------------

   // writes to status addresses fall through every decode: no effect
   always_comb begin
      rdata_d = spos_pkg::UNMAPPED_READ;
      if (reg_addr == spos_pkg::PIN_CODE_ADDR) begin
         rdata_d = pin_code_q;
      end else if (reg_addr == spos_pkg::SYS_STAT_ADDR) begin
         rdata_d = sys_snap_q;
      end else if (reg_addr >= spos_pkg::REF_STAT_BASE
                   && reg_addr < spos_pkg::REF_STAT_BASE + 16'(spos_pkg::REF_COUNT)) begin
         rdata_d = ref_byte(ref_snap_q, int'(reg_addr - spos_pkg::REF_STAT_BASE));
      end else if (reg_addr == spos_pkg::EVENT_ADDR) begin
         rdata_d = evt_snap_q;
      end else if (in_bank(reg_addr, spos_pkg::LOOP0_BASE)) begin
         rdata_d = bank_byte[0];
      end else if (in_bank(reg_addr, spos_pkg::LOOP0_BASE + spos_pkg::LOOP1_OFFSET)) begin
         rdata_d = bank_byte[1];
      end else if (in_bank(reg_addr, spos_pkg::LOOP0_BASE + spos_pkg::LOOP2_OFFSET)) begin
         rdata_d = bank_byte[2];
      end else if (in_bank(reg_addr, spos_pkg::LOOP0_BASE + spos_pkg::LOOP3_OFFSET)) begin
         rdata_d = bank_byte[3];
      end
   end

   // data stands only in the cycle after the read strobe
   always_ff @(posedge mclk) begin
      if (rst) begin
         reg_rdata <= spos_pkg::UNMAPPED_READ;
      end else if (reg_rd) begin
         reg_rdata <= rdata_d;
      end else begin
         reg_rdata <= spos_pkg::UNMAPPED_READ;
      end
   end

   // ---------------------------------------------------------------
   // timing sources for the pin
   // ---------------------------------------------------------------

   spos_strobe_gen #(
      .DIV_RATIO  (DIV_RATIO),
      .STROBE_LEN (STROBE_LEN)
   ) u_strobe (
      .mclk       (mclk),
      .rst        (rst),
      .wd_expire  (wd_expire),
      .div_clk    (div_clk),
      .wd_strobe  (wd_strobe)
   );

   // ---------------------------------------------------------------
   // output function mux
   // ---------------------------------------------------------------

   assign sub      = pin_code_q[3:0];
   assign sel_loop = pin_code_q[5:4];
   assign sel_b0   = loop_byte(loop_status, int'(sel_loop), 0);
   assign sel_b1   = loop_byte(loop_status, int'(sel_loop), 1);
   assign sel_b2   = loop_byte(loop_status, int'(sel_loop), 2);
   assign sel_ref  = ref_byte(ref_status, int'(sub[1:0]));

   // the pin follows live sources, not the snapshot, so it needs no update
   always_comb begin
      pin_d = 1'b0;
      if (pin_code_q[spos_pkg::BIT_DIR]) begin
         if (pin_code_q[7:4] == spos_pkg::GRP_MISC) begin
            case (sub)
               4'h0: pin_d = 1'b0;
               4'h1: pin_d = 1'b1;
               4'h2: pin_d = div_clk;
               4'h3: pin_d = wd_strobe;
               4'h4: pin_d = refmult_cal_busy;
               4'h5: pin_d = refmult_lock;
               4'h6: pin_d = refmult_stable;
               4'h7: pin_d = &comb_lock;
               4'h8, 4'h9, 4'hA, 4'hB: begin
                  pin_d = comb_lock[sub[1:0]];
               end
               default: pin_d = 1'b0;
            endcase
         end else if (pin_code_q[7:4] == spos_pkg::GRP_IRQ) begin
            case (sub)
               4'h0: pin_d = irq_common | (|irq_loop);
               4'h1: pin_d = irq_common;
               4'h2, 4'h3, 4'h4, 4'h5: begin
                  pin_d = irq_loop[2'(sub - 4'h2)];
               end
               default: pin_d = 1'b0;
            endcase
         end else if (pin_code_q[7:4] == spos_pkg::GRP_REF) begin
            case (sub)
               4'h0, 4'h1, 4'h2, 4'h3: begin
                  pin_d = sel_ref[spos_pkg::REF_FAULT_BIT];
               end
               4'h8, 4'h9, 4'hA, 4'hB: begin
                  pin_d = sel_ref[spos_pkg::REF_VALID_BIT];
               end
               default: pin_d = 1'b0;
            endcase
         end else if (pin_code_q[7:4] == spos_pkg::GRP_REF_USE) begin
            case (sub)
               4'h0, 4'h1, 4'h2, 4'h3: begin
                  pin_d = |sel_ref[7:4];
               end
               default: pin_d = 1'b0;
            endcase
         end else if (pin_code_q[7:6] == 2'b11) begin
            // 0xC0..0xFF: one nibble of codes per loop, same layout
            case (sub)
               4'h0: pin_d = sel_b0[spos_pkg::S0_PHASE_BIT];
               4'h1: pin_d = sel_b0[spos_pkg::S0_FREQ_BIT];
               4'h2: pin_d = sel_b0[spos_pkg::S0_ALOCK_BIT];
               4'h3: pin_d = sel_b0[spos_pkg::S0_ACAL_BIT];
               4'h4: begin
                  pin_d = 1'b0;
                  for (int r = 0; r < spos_pkg::REF_COUNT; r++) begin
                     pin_d = pin_d
                             | ref_status[r*8 + spos_pkg::REF_USE_LSB + int'(sel_loop)];
                  end
               end
               4'h5: pin_d = sel_b1[spos_pkg::S1_FREE_BIT];
               4'h6: pin_d = sel_b1[spos_pkg::S1_HOLD_BIT];
               4'h7: pin_d = sel_b1[spos_pkg::S1_SWITCH_BIT];
               4'h8: pin_d = sel_b2[spos_pkg::S2_HIST_BIT];
               4'h9: begin
                  // event source is only known for loop 0; others stay low
                  pin_d = (sel_loop == 2'b00) && event_status[spos_pkg::EVT_HIST_BIT];
               end
               4'hA: pin_d = sel_b2[spos_pkg::S2_FCLAMP_BIT];
               4'hB: pin_d = sel_b2[spos_pkg::S2_SLEW_BIT];
               4'hD: pin_d = sel_b2[spos_pkg::S2_DEMAP_BIT];
               default: pin_d = 1'b0;
            endcase
            // codes for all four loops above, loop 0 at 0xC0..0xCD
         end
      end
   end

   // one register stage isolates the pin from mux glitches
   always_ff @(posedge mclk) begin
      if (rst) begin
         mfp_out  <= 1'b0;
         mfp_oe_n <= 1'b1;
      end else begin
         mfp_out  <= pin_d;
         mfp_oe_n <= ~pin_code_q[spos_pkg::BIT_DIR];
      end
   end

endmodule // spos_pin_select

// *** spos_pin_monitor.sv ***
`timescale 1ns/1ps
module spos_pin_monitor (
   input  wire logic mclk,
   input  wire logic mfp_out,
   input  wire logic mfp_oe_n,
   output logic      pin_level
);
   logic last_q;
   // no pull on the board net: a released pin shows the inverse of its last level
   always_ff @(posedge mclk) begin
      if (!mfp_oe_n) last_q <= mfp_out;
   end
   assign pin_level = mfp_oe_n ? !last_q : mfp_out;
endmodule // spos_pin_monitor

// *** spos_pin_select_checker.sv ***
`timescale 1ns/1ps
module spos_pin_select_checker #(
   parameter int LOOPS      = 4,
   parameter int STROBE_LEN = spos_pkg::WD_STROBE_CYC
) (
   input wire logic                                      mclk,
   input wire logic                                      rst,
   input wire logic [spos_pkg::ADDR_W-1:0]               reg_addr,
   input wire logic [spos_pkg::DATA_W-1:0]               reg_wdata,
   input wire logic                                      reg_wr,
   input wire logic [LOOPS*spos_pkg::BANK_BYTES*8-1:0]   loop_status,
   input wire logic                                      refmult_lock,
   input wire logic                                      irq_common,
   input wire logic [LOOPS-1:0]                          irq_loop,
   input wire logic                                      wd_expire,
   input wire logic                                      mfp_out,
   input wire logic                                      mfp_oe_n
);
   logic [7:0] code_q;
   logic [7:0] code_d1_q;
   logic [5:0] wd_cnt_q;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   always_ff @(posedge mclk) begin
      if (rst) code_q <= spos_pkg::PIN_CODE_RST;
      else if (reg_wr && reg_addr == spos_pkg::PIN_CODE_ADDR) code_q <= reg_wdata;
   end
   // the pin lags the code register by one edge, so compare against the delayed copy
   always_ff @(posedge mclk) begin
      if (rst) code_d1_q <= spos_pkg::PIN_CODE_RST;
      else code_d1_q <= code_q;
   end
   always_ff @(posedge mclk) begin
      if (rst) wd_cnt_q <= 6'h3F;
      else if (wd_expire) wd_cnt_q <= 6'h01;
      else if (wd_cnt_q != 6'h3F) wd_cnt_q <= wd_cnt_q + 6'h01;
   end
   property p_oe_drive; !$past(rst) && code_d1_q[7] |-> !mfp_oe_n; endproperty
   property p_const_high; code_d1_q == 8'h81 |-> mfp_out; endproperty
   property p_unused_low; code_d1_q inside {8'h80, 8'h8C, 8'h8D, 8'h8E, 8'hCC} |-> !mfp_out;
   endproperty
   property p_irq_any; code_d1_q == 8'h90 |-> mfp_out == $past(irq_common || (|irq_loop));
   endproperty
   property p_mult_lock; code_d1_q == 8'h85 |-> mfp_out == $past(refmult_lock); endproperty
   property p_loop_lock;
      code_d1_q == 8'h88 |-> mfp_out == $past(loop_status[1] & loop_status[3] & refmult_lock);
   endproperty
   property p_wd_high;
      code_d1_q == 8'h83 && wd_cnt_q >= 2 && wd_cnt_q <= STROBE_LEN + 1 |-> mfp_out;
   endproperty
   property p_wd_end; code_d1_q == 8'h83 && wd_cnt_q == STROBE_LEN + 2 |-> !mfp_out; endproperty
   property p_div_half;
      code_d1_q == 8'h82 && $past(code_d1_q, 17) == 8'h82 |-> mfp_out != $past(mfp_out, 16);
   endproperty
   a_oe_drive: assert property (p_oe_drive) else $error("pin not driven");
   a_const_high: assert property (p_const_high) else $error("pin not high");
   a_unused_low: assert property (p_unused_low) else $error("pin not low");
   a_irq_any: assert property (p_irq_any) else $error("irq or wrong");
   a_mult_lock: assert property (p_mult_lock) else $error("lock wrong");
   a_loop_lock: assert property (p_loop_lock) else $error("loop lock wrong");
   a_wd_high: assert property (p_wd_high) else $error("strobe short");
   a_wd_end: assert property (p_wd_end) else $error("strobe long");
   a_div_half: assert property (p_div_half) else $error("divider wrong");
   c_wd: cover property (code_d1_q == 8'h83 && mfp_out);
   c_div: cover property (code_d1_q == 8'h82 && $rose(mfp_out));
   c_update: cover property (reg_wr && reg_addr == spos_pkg::UPDATE_ADDR);
endmodule // spos_pin_select_checker

bind spos_pin_select spos_pin_select_checker #(.LOOPS(LOOPS), .STROBE_LEN(STROBE_LEN))
   spos_pin_select_checker_i (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .loop_status(loop_status),
   .refmult_lock(refmult_lock), .irq_common(irq_common), .irq_loop(irq_loop),
   .wd_expire(wd_expire), .mfp_out(mfp_out), .mfp_oe_n(mfp_oe_n));

// *** tb_status_pin_output_select.sv ***
`timescale 1ns/1ps
module tb_status_pin_output_select;
   localparam logic [351:0] LS_A = {80'h0, 8'h02, 80'h0, 8'h0A, 80'h0, 8'h0A,
                                    64'h0, 8'h09, 8'h05, 8'h0A};
   // code, then expected pin for the plain pattern (bit 1) and its inverse (bit 0)
   localparam logic [11:0] ROWS [35] = '{12'h800, 12'h813, 12'h842, 12'h852, 12'h861,
      12'h870, 12'h882, 12'h892, 12'h8A2, 12'h8B0, 12'h8C0, 12'h903, 12'h911, 12'h921,
      12'h931, 12'h942, 12'h951, 12'hB03, 12'hB11, 12'hB23, 12'hB31, 12'hC02, 12'hC11,
      12'hC22, 12'hC31, 12'hC43, 12'hC52, 12'hC61, 12'hC72, 12'hC82, 12'hC92, 12'hCA1,
      12'hCB1, 12'hCC0, 12'hCD2};
   logic          mclk, rst, reg_wr, reg_rd, refmult_lock, refmult_stable, refmult_cal_busy;
   logic          irq_common, wd_expire, mfp_out, mfp_oe_n, update_busy, pin_level;
   logic [15:0]   reg_addr;
   logic [7:0]    reg_wdata, reg_rdata, event_status;
   logic [351:0]  loop_status;
   logic [31:0]   ref_status;
   logic [3:0]    irq_loop;
   int            error_cnt = 0;
   int            cmp_count = 0;
   spos_pin_select spos_pin_select_i (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .loop_status(loop_status), .refmult_lock(refmult_lock), .refmult_stable(refmult_stable),
      .refmult_cal_busy(refmult_cal_busy), .ref_status(ref_status),
      .event_status(event_status), .irq_common(irq_common), .irq_loop(irq_loop),
      .wd_expire(wd_expire), .mfp_out(mfp_out), .mfp_oe_n(mfp_oe_n),
      .update_busy(update_busy));
   spos_pin_monitor spos_pin_monitor_i (.mclk(mclk), .mfp_out(mfp_out),
      .mfp_oe_n(mfp_oe_n), .pin_level(pin_level));
   always #50 mclk = !mclk;
   task automatic finish_test();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic set_pat(input logic inv);
      @(posedge mclk);
      loop_status <= LS_A ^ {352{inv}};
      {refmult_lock, refmult_stable, refmult_cal_busy} <= 3'b101 ^ {3{inv}};
      ref_status <= 32'h0480_0010 ^ {32{inv}};
      event_status <= 8'h10 ^ {8{inv}};
      {irq_common, irq_loop} <= 5'b00100 ^ {5{inv}};
   endtask
   task automatic count_high(input int n, output int hi, output int tg);
      logic prev;
      hi = 0;
      tg = 0;
      #1 prev = mfp_out;
      for (int k = 0; k < n; k++) begin
         @(posedge mclk);
         #1 hi += (mfp_out === 1'b1);
         tg += (mfp_out !== prev);
         prev = mfp_out;
      end
   endtask
   initial begin
      repeat (50000) @(posedge mclk);
      error_cnt++;
      finish_test();
   end
   initial begin
      logic [7:0] d, e;
      int hi, tg;
      {mclk, rst, reg_wr, reg_rd, wd_expire, reg_addr, reg_wdata} = {5'b01000, 24'h0};
      {loop_status, ref_status, event_status} = '0;
      {refmult_lock, refmult_stable, refmult_cal_busy, irq_common, irq_loop} = '0;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      repeat (2) @(posedge mclk);
      #1 check8("oe_n", 8'h00, {7'h0, mfp_oe_n});
      check8("out", 8'h00, {7'h0, mfp_out});
      rd(spos_pkg::PIN_CODE_ADDR, d);
      check8("code", spos_pkg::PIN_CODE_RST, d);
      for (int l = 0; l < 4; l++) begin
         rd(spos_pkg::LOOP0_BASE + 16'(l) * 16'h0020, d);
         check8("bank reset", spos_pkg::STATUS_RST, d);
      end
      set_pat(1'b0);
      rd(16'h0D40, d);
      check8("stale", 8'h00, d);
      wr(spos_pkg::UPDATE_ADDR, spos_pkg::UPDATE_GO);
      #1 check8("busy", 8'h01, {7'h0, update_busy});
      for (int l = 0; l < 4; l++) begin
         for (int i = 0; i < spos_pkg::BANK_BYTES; i++) begin
            rd(spos_pkg::LOOP0_BASE + 16'(l) * 16'h0020 + 16'(i), d);
            check8("bank", LS_A[l*88+i*8 +: 8], d);
         end
      end
      wr(16'h0D60, 8'h55);
      wr(16'h0D6A, 8'hFF);
      rd(16'h0D60, d);
      check8("ro 0D60", 8'h0A, d);
      rd(16'h0D6A, d);
      check8("ro 0D6A", 8'h00, d);
      set_pat(1'b1);
      wr(spos_pkg::UPDATE_ADDR, 8'h02);
      rd(16'h0D20, d);
      check8("no update", 8'h0A, d);
      wr(spos_pkg::UPDATE_ADDR, spos_pkg::UPDATE_GO);
      rd(16'h0D20, d);
      check8("update", 8'hF5, d);
      rd(16'h0300, d);
      check8("unmapped", spos_pkg::UNMAPPED_READ, d);
      for (int p = 0; p < 2; p++) begin
         set_pat(p[0]);
         for (int r = 0; r < 35; r++) begin
            wr(spos_pkg::PIN_CODE_ADDR, ROWS[r][11:4]);
            @(posedge mclk);
            #1 e = {7'h0, ROWS[r][1-p]};
            d = {7'h0, pin_level};
            if (ROWS[r][11:8] < 4'hB) check8("pin", e, d);
            else check8("pin", e, d);
         end
      end
      set_pat(1'b0);
      @(posedge mclk);
      loop_status[3*88 +: 8] <= 8'h0A;
      wr(spos_pkg::PIN_CODE_ADDR, 8'h87);
      @(posedge mclk);
      #1 check8("all lock", 8'h01, {7'h0, pin_level});
      wr(spos_pkg::PIN_CODE_ADDR, 8'h01);
      @(posedge mclk);
      #1 check8("input oe_n", 8'h01, {7'h0, mfp_oe_n});
      wr(spos_pkg::PIN_CODE_ADDR, 8'h82);
      repeat (40) @(posedge mclk);
      count_high(2 * spos_pkg::CLK_DIV_RATIO, hi, tg);
      check8("div high", 8'(spos_pkg::CLK_DIV_RATIO), 8'(hi));
      check8("div edges", 8'h04, 8'(tg));
      wr(spos_pkg::PIN_CODE_ADDR, 8'h83);
      repeat (4) @(posedge mclk);
      wd_expire <= 1'b1;
      @(posedge mclk);
      wd_expire <= 1'b0;
      count_high(spos_pkg::WD_STROBE_CYC + 8, hi, tg);
      check8("strobe", 8'(spos_pkg::WD_STROBE_CYC), 8'(hi));
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      #1 check8("reset oe_n", 8'h01, {7'h0, mfp_oe_n});
      rst <= 1'b0;
      rd(16'h0D20, d);
      check8("bank rerst", spos_pkg::STATUS_RST, d);
      finish_test();
   end
endmodule // tb_status_pin_output_select
